//--- rtl/rfs_pkg.sv
// package: register map, field layout and defaults for the regulator four channel
package rfs_pkg;
    localparam logic [7:0] REG_CONTROL_ADDR = 8'hD1;
    localparam logic [7:0] REG_TIMEOUTS_ADDR = 8'hD2;
    localparam logic [7:0] REG_LOW_POWER_ADDR = 8'hD3;
    // control fields
    localparam int SWITCH_MODE_BIT = 14;
    localparam int FLOAT_OUTPUT_BIT = 10;
    localparam int VCODE_LSB = 0;
    // timeouts fields
    localparam int FAULT_ACT_LSB = 14;
    localparam int START_SLOT_LSB = 10;
    localparam int SHUT_SLOT_LSB = 6;
    // low power fields
    localparam int HIB_BEHAV_LSB = 12;
    localparam int HIB_TRIG_LSB = 8;
    localparam int IMG_VCODE_LSB = 0;
    // writable bit masks, reserved bits read zero
    localparam logic [15:0] CONTROL_MASK = 16'h441F;
    localparam logic [15:0] TIMEOUTS_MASK = 16'hFFC0;
    localparam logic [15:0] LOW_POWER_MASK = 16'h331F;
    // slot code meanings
    localparam logic [3:0] SLOT_NEVER = 4'h0;
    localparam logic [3:0] SLOT_ON_STATE = 4'hF;
    // fault action codes
    localparam logic [1:0] FAULT_IGNORE = 2'h0;
    localparam logic [1:0] FAULT_SHUT_REG = 2'h1;
    // hibernate behaviour codes
    localparam logic [1:0] HIB_IMAGE = 2'h0;
    localparam logic [1:0] HIB_DISABLE = 2'h1;
    // voltage mapping in millivolts
    localparam int LOW_BASE_MV = 900;
    localparam int LOW_STEP_MV = 50;
    localparam int HIGH_BASE_MV = 1800;
    localparam int HIGH_STEP_MV = 100;

    typedef struct packed {
        logic enable;
        logic discharge;
        logic switch_mode;
        logic [4:0] vcode;
        logic [11:0] millivolts;
    } rfs_analog_t;

    // output state in reset: disabled, so the output is discharged
    localparam rfs_analog_t ANALOG_RESET = '{enable: 1'b0, discharge: 1'b1, switch_mode: 1'b0,
        vcode: 5'h00, millivolts: 12'h000};

    // millivolt value of a 5-bit code
    function automatic logic [11:0] rfs_code_mv(input logic [4:0] code);
        int mv;
        mv = code[4] ? HIGH_BASE_MV + HIGH_STEP_MV * int'(code[3:0])
                     : LOW_BASE_MV + LOW_STEP_MV * int'(code[3:0]);
        return mv[11:0];
    endfunction : rfs_code_mv
endpackage : rfs_pkg

//--- rtl/rfs_channel.sv
// regulator four sequencing control: registers, slot sequencing, hibernate and fault policy
`timescale 1ns/1ps
module rfs_channel
    import rfs_pkg::*;
#(
    parameter logic [15:0] CONTROL_DEFAULT = 16'h001B,
    parameter logic [15:0] TIMEOUTS_DEFAULT = 16'h0000,
    parameter logic [15:0] LOW_POWER_DEFAULT = 16'h001C
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reinit,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output logic rdata_valid,
    input wire logic seq_active_entry,
    input wire logic seq_off_entry,
    input wire logic seq_startup_strobe,
    input wire logic seq_shutdown_strobe,
    input wire logic [3:0] seq_slot,
    input wire logic hibernate_reg_bit,
    input wire logic low_power_input_1,
    input wire logic low_power_input_2,
    input wire logic low_power_input_3,
    input wire logic others_disabled,
    input wire logic ch_fault,
    output rfs_analog_t analog,
    output logic fault_irq,
    output logic shutdown_system
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] control_reg;
    logic [15:0] timeouts_reg;
    logic [15:0] low_power_reg;
    logic seq_on_reg;
    logic [2:0] lp_meta_reg;
    logic [2:0] lp_sync_reg;
    logic fault_meta_reg;
    logic fault_sync_reg;
    logic fault_prev_reg;

    wire hit_control = addr == REG_CONTROL_ADDR;
    wire hit_timeouts = addr == REG_TIMEOUTS_ADDR;
    wire hit_low_power = addr == REG_LOW_POWER_ADDR;
    wire ch_switch_mode = control_reg[SWITCH_MODE_BIT];
    wire ch_float_output = control_reg[FLOAT_OUTPUT_BIT];
    wire [4:0] ch_voltage_code = control_reg[VCODE_LSB +: 5];
    wire [1:0] ch_fault_action = timeouts_reg[FAULT_ACT_LSB +: 2];
    wire [3:0] ch_startup_slot = timeouts_reg[START_SLOT_LSB +: 4];
    wire [3:0] ch_shutdown_slot = timeouts_reg[SHUT_SLOT_LSB +: 4];
    wire [1:0] ch_hibernate_behaviour = low_power_reg[HIB_BEHAV_LSB +: 2];
    wire [1:0] ch_hibernate_trigger_sel = low_power_reg[HIB_TRIG_LSB +: 2];
    wire [4:0] ch_image_voltage_code = low_power_reg[IMG_VCODE_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////
    // register file; reinit acts like reset but is driven by the device state machine
    always_ff @(posedge clk)
    begin
        if (rst || reinit)
        begin
            control_reg <= CONTROL_DEFAULT & CONTROL_MASK;
            timeouts_reg <= TIMEOUTS_DEFAULT & TIMEOUTS_MASK;
            low_power_reg <= LOW_POWER_DEFAULT & LOW_POWER_MASK;
        end
        else if (wr_en)
        begin
            if (hit_control)
                control_reg <= wdata & CONTROL_MASK;
            else if (hit_timeouts)
                timeouts_reg <= wdata & TIMEOUTS_MASK;
            else if (hit_low_power)
                low_power_reg <= wdata & LOW_POWER_MASK;
        end
    end

    wire [15:0] rdata_next = hit_control ? control_reg
                           : hit_timeouts ? timeouts_reg
                           : hit_low_power ? low_power_reg : 16'h0000;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= 16'h0000;
            rdata_valid <= 1'b0;
        end
        else
        begin
            rdata <= rd_en ? rdata_next : 16'h0000;
            rdata_valid <= rd_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin-level inputs cross two flops before use
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lp_meta_reg <= 3'h0;
            lp_sync_reg <= 3'h0;
            fault_meta_reg <= 1'b0;
            fault_sync_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
        end
        else
        begin
            lp_meta_reg <= {low_power_input_3, low_power_input_2, low_power_input_1};
            lp_sync_reg <= lp_meta_reg;
            fault_meta_reg <= ch_fault;
            fault_sync_reg <= fault_meta_reg;
            fault_prev_reg <= fault_sync_reg;
        end
    end

    wire fault_event = fault_sync_reg && !fault_prev_reg;
    wire hib_trigger = (ch_hibernate_trigger_sel == 2'h0) ? hibernate_reg_bit
                     : lp_sync_reg[ch_hibernate_trigger_sel - 2'h1];
    wire hib_disable = hib_trigger && ch_hibernate_behaviour == HIB_DISABLE;
    wire hib_image = hib_trigger && ch_hibernate_behaviour == HIB_IMAGE;
    wire fault_shut_reg = fault_event && ch_fault_action == FAULT_SHUT_REG;
    wire fault_shut_sys = fault_event && ch_fault_action[1];

    ////////////////////////////////////////////////////////////////////////
    // slot sequencing; a shutdown wins over a start in the same cycle
    wire start_hit = (ch_startup_slot == SLOT_ON_STATE) ? seq_active_entry
                   : (ch_startup_slot != SLOT_NEVER && seq_startup_strobe && seq_slot == ch_startup_slot);
    wire shut_on_off = ch_shutdown_slot == SLOT_NEVER || ch_shutdown_slot == SLOT_ON_STATE;
    wire shut_hit = shut_on_off ? seq_off_entry
                  : (seq_shutdown_strobe && seq_slot == ch_shutdown_slot);
    wire seq_on_next = (shut_hit || fault_shut_reg) ? 1'b0 : (start_hit ? 1'b1 : seq_on_reg);

    always_ff @(posedge clk)
    begin
        if (rst)
            seq_on_reg <= 1'b0;
        else
            seq_on_reg <= seq_on_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // output state; hibernate is a level, so release restores automatically
    wire out_enable = seq_on_next && !hib_disable;
    wire [4:0] code_sel = hib_image ? ch_image_voltage_code : ch_voltage_code;
    wire all_off = !out_enable && others_disabled;
    rfs_analog_t analog_next;
    always_comb
    begin
        analog_next.enable = out_enable;
        analog_next.discharge = !out_enable && (!ch_float_output || all_off);
        analog_next.switch_mode = ch_switch_mode;
        // switch mode ignores the code, so report zero voltage
        analog_next.vcode = ch_switch_mode ? 5'h00 : code_sel;
        analog_next.millivolts = ch_switch_mode ? 12'h000 : rfs_code_mv(code_sel);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            analog <= ANALOG_RESET;
            fault_irq <= 1'b0;
            shutdown_system <= 1'b0;
        end
        else
        begin
            analog <= analog_next;
            fault_irq <= fault_event;
            shutdown_system <= fault_shut_sys;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_reinit_defaults: assert property (@(posedge clk) disable iff (rst)
        reinit |=> control_reg == (CONTROL_DEFAULT & CONTROL_MASK) && timeouts_reg == (TIMEOUTS_DEFAULT & TIMEOUTS_MASK))
        else $error("reinit did not restore defaults");
    a_switch_no_code: assert property (@(posedge clk) disable iff (rst)
        analog.switch_mode |-> analog.vcode == 5'h00 && analog.millivolts == 12'h000)
        else $error("switch mode still reports a voltage");
    a_float_respected: assert property (@(posedge clk) disable iff (rst)
        !analog.enable && !$past(ch_float_output) |-> analog.discharge)
        else $error("disabled output not discharged");
    a_all_off_discharge: assert property (@(posedge clk) disable iff (rst)
        !analog.enable && $past(others_disabled) |-> analog.discharge)
        else $error("all channels off but no discharge");
    a_code_mapping: assert property (@(posedge clk) disable iff (rst)
        !analog.switch_mode && analog.vcode == 5'h10 |-> analog.millivolts == 12'd1800)
        else $error("code 10000 is not 1.8V");
    a_fault_irq: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_sync_reg) |=> fault_irq ##1 !fault_irq)
        else $error("fault did not pulse interrupt");
    a_fault_system: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_sync_reg) && timeouts_reg[15] |=> shutdown_system)
        else $error("system shutdown missing");
    a_start_never: assert property (@(posedge clk) disable iff (rst || reinit)
        ch_startup_slot == SLOT_NEVER && !seq_on_reg && !seq_active_entry |=> !seq_on_reg)
        else $error("channel started with slot zero");
    a_shut_off_entry: assert property (@(posedge clk) disable iff (rst)
        seq_off_entry && shut_on_off |=> !seq_on_reg && !analog.enable)
        else $error("off entry did not shut channel");
    a_hib_disable: assert property (@(posedge clk) disable iff (rst)
        hib_disable |=> !analog.enable)
        else $error("hibernate disable left output on");
    a_hib_image: assert property (@(posedge clk) disable iff (rst)
        hib_image && !ch_switch_mode |=> analog.vcode == $past(ch_image_voltage_code))
        else $error("image code not applied");
    a_hib_release: assert property (@(posedge clk) disable iff (rst)
        !hib_trigger && seq_on_next |=> analog.enable)
        else $error("output not restored after hibernate");
    a_reinit_low_power: assert property (@(posedge clk) disable iff (rst)
        reinit |=> low_power_reg == (LOW_POWER_DEFAULT & LOW_POWER_MASK))
        else $error("reinit did not restore low power defaults");
    a_write_lands: assert property (@(posedge clk) disable iff (rst)
        wr_en && !reinit && hit_timeouts |=> timeouts_reg == ($past(wdata) & TIMEOUTS_MASK))
        else $error("timeouts write did not land");
    a_read_back: assert property (@(posedge clk) disable iff (rst)
        rd_en && hit_low_power |=> rdata_valid && rdata == $past(low_power_reg))
        else $error("low power read returned wrong data");
    a_read_idle: assert property (@(posedge clk) disable iff (rst)
        !rd_en |=> !rdata_valid && rdata == 16'h0000)
        else $error("read data shown without a read");
    a_enabled_no_drain: assert property (@(posedge clk) disable iff (rst)
        analog.enable |-> !analog.discharge)
        else $error("enabled output is being discharged");
    a_float_kept: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !analog.enable && $past(ch_float_output) && !$past(others_disabled) |-> !analog.discharge)
        else $error("floating output was discharged");
    a_low_code: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !analog.switch_mode && !analog.vcode[4]
        |-> analog.millivolts == 12'(LOW_BASE_MV + LOW_STEP_MV * int'(analog.vcode[3:0])))
        else $error("low half code maps to wrong voltage");
    a_high_code: assert property (@(posedge clk) disable iff (rst)
        !analog.switch_mode && analog.vcode[4]
        |-> analog.millivolts == 12'(HIGH_BASE_MV + HIGH_STEP_MV * int'(analog.vcode[3:0])))
        else $error("high half code maps to wrong voltage");
    a_fault_ignore: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_sync_reg) && ch_fault_action == FAULT_IGNORE |=> fault_irq && !shutdown_system)
        else $error("ignored fault still acted");
    a_fault_reg_off: assert property (@(posedge clk) disable iff (rst)
        fault_shut_reg |=> !seq_on_reg && !analog.enable)
        else $error("regulator fault did not shut channel");
    a_irq_needs_fault: assert property (@(posedge clk) disable iff (rst)
        !fault_event |=> !fault_irq)
        else $error("interrupt without a fault edge");
    a_start_slot: assert property (@(posedge clk) disable iff (rst)
        seq_startup_strobe && ch_startup_slot != SLOT_NEVER && ch_startup_slot != SLOT_ON_STATE
        && seq_slot == ch_startup_slot && !shut_hit && !fault_shut_reg |=> seq_on_reg)
        else $error("start slot missed");
    a_start_active: assert property (@(posedge clk) disable iff (rst)
        seq_active_entry && ch_startup_slot == SLOT_ON_STATE && !shut_hit && !fault_shut_reg |=> seq_on_reg)
        else $error("active entry did not start channel");
    a_start_needs_event: assert property (@(posedge clk) disable iff (rst)
        !seq_on_reg && !seq_startup_strobe && !seq_active_entry |=> !seq_on_reg)
        else $error("channel started without a start event");
    a_shut_slot: assert property (@(posedge clk) disable iff (rst)
        seq_shutdown_strobe && !shut_on_off && seq_slot == ch_shutdown_slot |=> !seq_on_reg && !analog.enable)
        else $error("shutdown slot missed");
    a_shut_strobe_ignored: assert property (@(posedge clk) disable iff (rst)
        seq_on_reg && shut_on_off && seq_shutdown_strobe && !seq_off_entry && !fault_shut_reg |=> seq_on_reg)
        else $error("slot strobe shut a channel set to shut on off entry");
    a_hib_image_on: assert property (@(posedge clk) disable iff (rst)
        hib_image && seq_on_next |=> analog.enable)
        else $error("image hibernate disabled the output");
    a_trig_reg_bit: assert property (@(posedge clk) disable iff (rst)
        ch_hibernate_trigger_sel == 2'h0 && hibernate_reg_bit && ch_hibernate_behaviour == HIB_DISABLE
        |=> !analog.enable)
        else $error("register bit did not trigger hibernate");
    a_trig_third_pin: assert property (@(posedge clk) disable iff (rst)
        ch_hibernate_trigger_sel == 2'h3 && lp_sync_reg[2] && ch_hibernate_behaviour == HIB_DISABLE
        |=> !analog.enable)
        else $error("third low-power input did not trigger hibernate");
    a_trig_pin_quiet: assert property (@(posedge clk) disable iff (rst)
        ch_hibernate_trigger_sel == 2'h1 && !lp_sync_reg[0] |-> !hib_trigger)
        else $error("hibernate seen with its input low");
    a_image_voltage: assert property (@(posedge clk) disable iff (rst)
        hib_image && !ch_switch_mode |=> analog.millivolts == $past(rfs_code_mv(ch_image_voltage_code)))
        else $error("image voltage not applied");
    a_normal_code: assert property (@(posedge clk) disable iff (rst)
        !hib_image && !ch_switch_mode |=> analog.vcode == $past(ch_voltage_code))
        else $error("normal code not restored");
    a_switch_follows: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> analog.switch_mode == $past(ch_switch_mode))
        else $error("switch mode not passed to the output");

    ////////////////////////////////////////////////////////////////////////
    // cover points for the main scenarios
    c_startup: cover property (@(posedge clk) disable iff (rst) $rose(seq_on_reg));
    c_hib_image: cover property (@(posedge clk) disable iff (rst) hib_image && seq_on_reg);
    c_fault_reg: cover property (@(posedge clk) disable iff (rst) fault_shut_reg && seq_on_reg);
    c_hib_disable: cover property (@(posedge clk) disable iff (rst) hib_disable && seq_on_reg);
    c_system_fault: cover property (@(posedge clk) disable iff (rst) fault_shut_sys);
endmodule : rfs_channel

//--- testbench/rfs_channel_bench.sv
// self-checking bench for the regulator four sequencing control
`timescale 1ns/1ps
module rfs_channel_bench;
    import rfs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reinit = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rdata_valid, fault_irq, shutdown_system;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, c16;
    logic act_e = 1'b0, off_e = 1'b0, st_s = 1'b0, sd_s = 1'b0, hib = 1'b0, odis = 1'b0, flt = 1'b0;
    logic [3:0] slot = 4'h0, s;
    logic [2:0] lp = 3'h0;
    logic [4:0] c, m;
    rfs_analog_t analog;
    int num_errors = 0, cmp_count = 0, cycles = 0;
    logic [7:0] adr_tab [4] = '{8'hD1, 8'hD2, 8'hD3, 8'hD0};
    logic [15:0] msk_tab [4] = '{16'h441F, 16'hFFC0, 16'h331F, 16'h0000};
    logic [15:0] sh [4];
    always #2.5 clk = ~clk;
    rfs_channel i_rfs_channel (.clk(clk), .rst(rst), .reinit(reinit), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rdata_valid(rdata_valid), .seq_active_entry(act_e), .seq_off_entry(off_e),
        .seq_startup_strobe(st_s), .seq_shutdown_strobe(sd_s), .seq_slot(slot), .hibernate_reg_bit(hib),
        .low_power_input_1(lp[0]), .low_power_input_2(lp[1]), .low_power_input_3(lp[2]), .others_disabled(odis),
        .ch_fault(flt), .analog(analog), .fault_irq(fault_irq), .shutdown_system(shutdown_system));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally(input bit ok, input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (!ok)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : tally
    task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
        tally(g === e, {16'h0000, g}, {16'h0000, e});
    endtask : chk_reg
    task automatic chk_bit(input logic g, input logic e);
        tally(g === e, {31'h0, g}, {31'h0, e});
    endtask : chk_bit
    task automatic chk_ana(input rfs_analog_t g, input rfs_analog_t e);
        tally(g === e, {12'h000, g}, {12'h000, e});
    endtask : chk_ana
    // expected analog word; switch mode reports no code
    function automatic rfs_analog_t ana(input logic sw, input logic [4:0] cd);
        rfs_analog_t a;
        int mv;
        mv = cd[4] ? 1800 + 100 * int'(cd[3:0]) : 900 + 50 * int'(cd[3:0]);
        a.enable = 1'b1;
        a.discharge = 1'b0;
        a.switch_mode = sw;
        a.vcode = sw ? 5'h00 : cd;
        a.millivolts = sw ? 12'h000 : mv[11:0];
        return a;
    endfunction : ana
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        {wr_en, addr, wdata} = {1'b1, a, d};
        @(negedge clk);
        wr_en = 1'b0;
        // one more edge so the outputs already follow the new field
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        {rd_en, addr} = {1'b1, a};
        @(negedge clk);
        rd_en = 1'b0;
        // answer stands only in the cycle after the strobe edge
        chk_bit(rdata_valid, 1'b1);
        chk_reg(rdata, e);
    endtask : rd
    // one-cycle sequencer pulse: {startup, shutdown, active entry, off entry}
    task automatic seq(input logic [3:0] w, input logic [3:0] sl);
        @(negedge clk);
        {st_s, sd_s, act_e, off_e, slot} = {w, sl};
        @(negedge clk);
        {st_s, sd_s, act_e, off_e} = 4'h0;
    endtask : seq
    task automatic done(input string n);
        $display("test %s done", n);
    endtask : done
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(7));
        cyc(10);
        rst = 1'b0;
        rd(8'hD1, 16'h001B);
        rd(8'hD2, 16'h0000);
        rd(8'hD3, 16'h001C);
        chk_bit(analog.discharge, 1'b1);
        done("defaults");
        sh = '{16'h001B, 16'h0000, 16'h001C, 16'h0000};
        for (int i = 0; i < 16; i++)
        begin
            automatic int k = $urandom % 4;
            c16 = $urandom;
            wr(adr_tab[k], c16);
            sh[k] = c16 & msk_tab[k];
            rd(adr_tab[k], sh[k]);
        end
        @(negedge clk) reinit = 1'b1;
        @(negedge clk) reinit = 1'b0;
        rd(8'hD1, 16'h001B);
        rd(8'hD2, 16'h0000);
        rd(8'hD3, 16'h001C);
        done("registers");
        s = 4'(1 + $urandom % 13);
        c = 5'($urandom);
        wr(8'hD2, {2'b00, s, s + 4'h1, 6'h00});
        seq(4'h8, s + 4'h1);
        chk_bit(analog.enable, 1'b0);
        seq(4'h8, s);
        chk_ana(analog, ana(1'b0, 5'h1B));
        wr(8'hD1, {11'h000, c});
        chk_ana(analog, ana(1'b0, c));
        seq(4'h4, s + 4'h1);
        chk_bit(analog.enable, 1'b0);
        chk_bit(analog.discharge, 1'b1);
        wr(8'hD1, {11'h020, c});
        chk_bit(analog.discharge, 1'b0);
        @(negedge clk) odis = 1'b1;
        cyc(1);
        chk_bit(analog.discharge, 1'b1);
        odis = 1'b0;
        done("slots");
        seq(4'h2, 4'h1);
        chk_bit(analog.enable, 1'b0);
        wr(8'hD2, {6'h0F, 10'h000});
        seq(4'h2, 4'h1);
        seq(4'h4, 4'h1);
        chk_bit(analog.enable, 1'b1);
        wr(8'hD1, {11'h200, c});
        chk_ana(analog, ana(1'b1, c));
        wr(8'hD1, {11'h000, c});
        seq(4'h1, 4'h1);
        chk_bit(analog.enable, 1'b0);
        done("modes");
        seq(4'h2, 4'h1);
        m = 5'($urandom);
        wr(8'hD3, {11'h000, m});
        @(negedge clk) hib = 1'b1;
        cyc(2);
        chk_ana(analog, ana(1'b0, m));
        hib = 1'b0;
        cyc(2);
        chk_ana(analog, ana(1'b0, c));
        for (int t = 0; t < 4; t++)
        begin
            wr(8'hD3, {6'h04, 2'(t), 8'h00});
            {hib, lp} = (t == 0) ? 4'h8 : 4'(1 << (t - 1));
            cyc(4);
            chk_bit(analog.enable, 1'b0);
            {hib, lp} = 4'h0;
            cyc(4);
            chk_bit(analog.enable, 1'b1);
        end
        done("hibernate");
        for (int a = 0; a < 4; a++)
        begin
            wr(8'hD2, {2'(a), 14'h3C00});
            seq(4'h2, 4'h1);
            @(negedge clk) flt = 1'b1;
            for (int i = 0; i < 8 && fault_irq !== 1'b1; i++)
                @(posedge clk) #1;
            chk_bit(fault_irq, 1'b1);
            chk_bit(shutdown_system, a >= 2);
            chk_bit(analog.enable, a != 1);
            @(posedge clk) #1;
            chk_bit(fault_irq, 1'b0);
            @(negedge clk) flt = 1'b0;
            cyc(4);
        end
        done("faults");
        wrap_up();
    end
endmodule : rfs_channel_bench
